// [core/fan_params.svh]
// Purpose: Named offsets, fields, reset values and timing figures of the fan block
// Assumes: Included by its bare name from the design file
// Notes: Definitions only
`ifndef FAN_PARAMS_SVH
`define FAN_PARAMS_SVH
// Register offsets
`define TACH_LOW_ADDR 8'h46
`define TACH_HIGH_ADDR 8'h47
`define LUT_BASE_ADDR 8'h50
`define LUT_LAST_ADDR 8'h67
`define CFG_ADDR 8'h68
`define HYST_ADDR 8'h69
// Configuration fields
`define CFG_INTV_LSB 0
`define CFG_INTV_MSB 1
`define CFG_HIRES_BIT 2
`define CFG_HALFDEG_BIT 3
`define CFG_SMOOTH_BIT 4
`define CFG_BETA_BIT 5
// Reset values
`define CFG_RESET 8'h14
`define HYST_RESET 8'h01
`define LUT_RESET 8'h00
// Tach pin rests high on its pull-up, so the synchroniser starts there
`define TACH_IDLE 1'b1
// Duty, tach count and table size figures
`define FULL_DUTY 8'hff
`define ZERO_DUTY 8'h00
`define FINE_STEP 8'h01
`define COARSE_STEP 8'h10
`define TACH_MAX 16'hffff
`define LUT_PAIRS 12
// Timing
`define CLK_HZ 40000000
`define CLK_PERIOD_NS 25
`define SMOOTH_BASE_NS 23000000
`define TACH_CLK_HZ 90000
`define TACH_DIV_CYCLES (`CLK_HZ / `TACH_CLK_HZ)
`endif

// [core/fan_pkg.sv]
// Purpose: Types shared by the fan control block
// Assumes: Constants live in fan_params.svh
// Notes: Nothing here is imported; users write fan_pkg::name
package fan_pkg;
  // One duty or temperature byte
  typedef logic [7:0] byte_t;
  // Smoothing interval selection, each code doubles the previous interval
  typedef enum logic [1:0] {
    INTV_023 = 2'b00,
    INTV_046 = 2'b01,
    INTV_091 = 2'b10,
    INTV_182 = 2'b11
  } smoothIntv_t;
endpackage : fan_pkg

// [core/fan_lut_smoothing_tach.sv]
// Purpose: Lookup-table fan duty control with smoothing, hysteresis and tach count
// Assumes: remoteTemp and critTempOut come from logic on clk; tachIn is a pin
// Notes: Register port is the byte back end of the serial host interface
`timescale 1ns/100ps
`default_nettype none
`include "fan_params.svh"

module fan_lut_smoothing_tach #(
  parameter int unsigned SMOOTH_BASE_CYCLES = `SMOOTH_BASE_NS / `CLK_PERIOD_NS,
  parameter int unsigned LUT_PAIRS = `LUT_PAIRS
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  input wire logic [8:0] remoteTemp,
  input wire logic critTempOut,
  input wire logic tachIn,
  output logic [7:0] regRdData,
  output logic pwmOut,
  output logic pwmOe,
  output logic [7:0] dutyCycle,
  output logic remoteModeBeta
);

  // Programmable state
  fan_pkg::byte_t lutTemp_reg [LUT_PAIRS];
  fan_pkg::byte_t lutTemp_next [LUT_PAIRS];
  fan_pkg::byte_t lutDuty_reg [LUT_PAIRS];
  fan_pkg::byte_t lutDuty_next [LUT_PAIRS];
  fan_pkg::byte_t cfg_reg, cfg_next;
  fan_pkg::byte_t hyst_reg, hyst_next;
  fan_pkg::byte_t rdData_reg, rdData_next;
  // Control state
  logic [3:0] lutIdx_reg, lutIdx_next;
  fan_pkg::byte_t duty_reg, duty_next;
  logic [23:0] intvCnt_reg, intvCnt_next;
  logic [7:0] pwmCnt_reg, pwmCnt_next;
  logic pwmOe_reg, pwmOe_next;
  // Tach state
  logic [2:0] tachSync_reg, tachSync_next;
  logic tachLevel_reg, tachLevel_next;
  logic pulseOdd_reg, pulseOdd_next;
  logic [8:0] tachDiv_reg, tachDiv_next;
  logic [15:0] tachCnt_reg, tachCnt_next;
  logic [15:0] tachCount_reg, tachCount_next;
  // Derived terms
  fan_pkg::byte_t targetDuty;
  logic [8:0] tempCmp;
  logic [23:0] periodCycles;
  logic stepTick, smoothOn, tachRise, revEdge, tick90;
  fan_pkg::smoothIntv_t intvSel;

  // Set-point in half degrees, lowered by hysteresis when asked, floored at zero
  function automatic logic [8:0] setPoint(input logic [7:0] sp, input logic [7:0] hyst,
                                          input logic lower);
    logic [7:0] base;
    base = sp;
    if (lower) begin
      base = (sp > hyst) ? sp - hyst : `ZERO_DUTY;
    end
    return {base, 1'b0};
  endfunction : setPoint

  // One step from cur toward tgt, never overshooting
  function automatic logic [7:0] stepToward(input logic [7:0] cur, input logic [7:0] tgt,
                                            input logic [7:0] step);
    logic [7:0] out;
    out = cur;
    if (tgt > cur) begin
      out = (tgt - cur > step) ? cur + step : tgt;
    end else if (tgt < cur) begin
      out = (cur - tgt > step) ? cur - step : tgt;
    end
    return out;
  endfunction : stepToward

  // Register writes and read mux
  always_comb begin
    lutTemp_next = lutTemp_reg;
    lutDuty_next = lutDuty_reg;
    cfg_next = cfg_reg;
    hyst_next = hyst_reg;
    rdData_next = `ZERO_DUTY;
    // Table writes: even offset temperature, odd offset duty
    if (regWrEn && regAddr >= `LUT_BASE_ADDR && regAddr <= `LUT_LAST_ADDR) begin
      if (regAddr[0]) begin
        lutDuty_next[4'((regAddr - `LUT_BASE_ADDR) >> 1)] = regWrData;
      end else begin
        lutTemp_next[4'((regAddr - `LUT_BASE_ADDR) >> 1)] = regWrData;
      end
    end
    if (regWrEn && regAddr == `CFG_ADDR) begin
      cfg_next = regWrData;
    end
    if (regWrEn && regAddr == `HYST_ADDR) begin
      hyst_next = regWrData;
    end
    // Read data; unmapped offsets read zero
    if (regAddr >= `LUT_BASE_ADDR && regAddr <= `LUT_LAST_ADDR) begin
      rdData_next = regAddr[0] ? lutDuty_reg[4'((regAddr - `LUT_BASE_ADDR) >> 1)]
                               : lutTemp_reg[4'((regAddr - `LUT_BASE_ADDR) >> 1)];
    end else begin
      unique case (regAddr)
        `TACH_LOW_ADDR: rdData_next = tachCount_reg[7:0];
        `TACH_HIGH_ADDR: rdData_next = tachCount_reg[15:8];
        `CFG_ADDR: rdData_next = cfg_reg;
        `HYST_ADDR: rdData_next = hyst_reg;
        default: rdData_next = `ZERO_DUTY;
      endcase
    end
  end

  // Table index search and duty ramp
  always_comb begin
    tempCmp = cfg_reg[`CFG_HALFDEG_BIT] ? remoteTemp : {remoteTemp[8:1], 1'b0};
    lutIdx_next = 4'h0;
    for (int i = 0; i < LUT_PAIRS; i++) begin
      if (tempCmp > setPoint(lutTemp_reg[i], hyst_reg, i < lutIdx_reg)) begin
        lutIdx_next = lutIdx_next + 4'h1;
      end
    end
    targetDuty = (lutIdx_reg == 4'h0) ? `ZERO_DUTY : lutDuty_reg[lutIdx_reg - 4'h1];
    intvSel = fan_pkg::smoothIntv_t'(cfg_reg[`CFG_INTV_MSB:`CFG_INTV_LSB]);
    periodCycles = 24'(SMOOTH_BASE_CYCLES) << intvSel;
    stepTick = (intvCnt_reg == 24'h0);
    intvCnt_next = stepTick ? periodCycles - 24'h1 : intvCnt_reg - 24'h1;
    smoothOn = cfg_reg[`CFG_SMOOTH_BIT];
    if (critTempOut) begin
      duty_next = `FULL_DUTY;
    end else if (!smoothOn) begin
      duty_next = targetDuty;
    end else if (stepTick) begin
      duty_next = stepToward(duty_reg, targetDuty,
                             cfg_reg[`CFG_HIRES_BIT] ? `FINE_STEP : `COARSE_STEP);
    end else begin
      duty_next = duty_reg;
    end
    // Open-drain pin pulls low in the off part of each frame
    pwmCnt_next = pwmCnt_reg + 8'h01;
    pwmOe_next = (duty_reg != `FULL_DUTY) && (pwmCnt_reg >= duty_reg);
  end

  // Tach synchroniser, reference divider and period counter
  always_comb begin
    tachSync_next = {tachSync_reg[1:0], tachIn};
    tachLevel_next = (tachSync_reg[1] == tachSync_reg[2]) ? tachSync_reg[2] : tachLevel_reg;
    tachRise = (tachSync_reg[1] == tachSync_reg[2]) && tachSync_reg[2] && !tachLevel_reg;
    pulseOdd_next = tachRise ? !pulseOdd_reg : pulseOdd_reg;
    revEdge = tachRise && pulseOdd_reg;
    tick90 = (tachDiv_reg == 9'(`TACH_DIV_CYCLES - 1));
    tachDiv_next = tick90 ? 9'h000 : tachDiv_reg + 9'h001;
    tachCount_next = revEdge ? tachCnt_reg : tachCount_reg;
    if (revEdge) begin
      tachCnt_next = 16'h0000;
    end else if (tick90 && tachCnt_reg != `TACH_MAX) begin
      tachCnt_next = tachCnt_reg + 16'h0001;
    end else begin
      tachCnt_next = tachCnt_reg;
    end
  end

  // Register all state
  always_ff @(posedge clk) begin
    if (!nrst) begin
      for (int i = 0; i < LUT_PAIRS; i++) begin
        lutTemp_reg[i] <= `LUT_RESET;
        lutDuty_reg[i] <= `LUT_RESET;
      end
      cfg_reg <= `CFG_RESET;
      hyst_reg <= `HYST_RESET;
      rdData_reg <= `ZERO_DUTY;
      lutIdx_reg <= 4'h0;
      duty_reg <= `ZERO_DUTY;
      intvCnt_reg <= 24'h0;
      pwmCnt_reg <= 8'h00;
      pwmOe_reg <= 1'b0;
      // Idle-high start avoids a false tach rise after reset
      tachSync_reg <= {3{`TACH_IDLE}};
      tachLevel_reg <= `TACH_IDLE;
      pulseOdd_reg <= 1'b0;
      tachDiv_reg <= 9'h000;
      tachCnt_reg <= 16'h0000;
      tachCount_reg <= 16'h0000;
    end else begin
      lutTemp_reg <= lutTemp_next;
      lutDuty_reg <= lutDuty_next;
      cfg_reg <= cfg_next;
      hyst_reg <= hyst_next;
      rdData_reg <= rdData_next;
      lutIdx_reg <= lutIdx_next;
      duty_reg <= duty_next;
      intvCnt_reg <= intvCnt_next;
      pwmCnt_reg <= pwmCnt_next;
      pwmOe_reg <= pwmOe_next;
      tachSync_reg <= tachSync_next;
      tachLevel_reg <= tachLevel_next;
      pulseOdd_reg <= pulseOdd_next;
      tachDiv_reg <= tachDiv_next;
      tachCnt_reg <= tachCnt_next;
      tachCount_reg <= tachCount_next;
    end
  end

  // Outputs straight from flops; the pin data is a constant low
  assign regRdData = rdData_reg;
  assign pwmOut = 1'b0;
  assign pwmOe = pwmOe_reg;
  assign dutyCycle = duty_reg;
  assign remoteModeBeta = cfg_reg[`CFG_BETA_BIT];

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  crit_full_duty_a: assert property (critTempOut |=> dutyCycle == `FULL_DUTY)
    else $error("critical output did not force full duty");
  step_size_a: assert property (!critTempOut && smoothOn |=>
      (duty_reg >= $past(duty_reg) ? duty_reg - $past(duty_reg) : $past(duty_reg) - duty_reg)
      <= ($past(cfg_reg[`CFG_HIRES_BIT]) ? `FINE_STEP : `COARSE_STEP))
    else $error("duty moved more than one step");
  step_interval_a: assert property (!critTempOut && smoothOn && !stepTick
      |=> $stable(duty_reg))
    else $error("duty moved between interval ticks");
  ramp_stop_a: assert property (!critTempOut && smoothOn && duty_reg == targetDuty
      |=> duty_reg == $past(duty_reg))
    else $error("ramp moved past target");
  hyst_hold_a: assert property (lutIdx_reg != 4'h0 && !$past(regWrEn)
      && tempCmp > setPoint(lutTemp_reg[lutIdx_reg - 4'h1], hyst_reg, 1'b1)
      |=> lutIdx_reg >= $past(lutIdx_reg))
    else $error("stepped down inside hysteresis band");
  tach_latch_a: assert property (revEdge |=> tachCount_reg == $past(tachCnt_reg)
      && tachCnt_reg == 16'h0000)
    else $error("tach count not latched on revolution");
  tach_sat_a: assert property (tachCnt_reg == `TACH_MAX && !revEdge
      |=> tachCnt_reg == `TACH_MAX)
    else $error("tach counter wrapped");
  tach_bytes_a: assert property (regAddr == `TACH_HIGH_ADDR
      |=> regRdData == $past(tachCount_reg[15:8]))
    else $error("tach high byte read wrong");
  two_pulse_a: assert property (tachRise && !pulseOdd_reg |=> !revEdge[*2])
    else $error("latched on odd pulse");

  ramp_up_c: cover property (smoothOn && stepTick && targetDuty > duty_reg);
  ramp_down_c: cover property (smoothOn && stepTick && targetDuty < duty_reg);
  crit_c: cover property (!critTempOut ##1 critTempOut);
  tach_c: cover property (revEdge);

endmodule : fan_lut_smoothing_tach

`default_nettype wire

// [tb/fan_model.sv]
// Purpose: Four-pin fan seen from the fan block: PWM pin in, tach pulses out
// Assumes: Tach line has a pull-up, so it rests high while the fan stands
// Notes: Speed is fixed by HALF; onCnt counts cycles with the PWM pin released
`timescale 1ns/100ps
`default_nettype none
module fan_model #(
  parameter int HALF = 2220
) (
  input wire logic clk,
  input wire logic pwmPin,
  input wire logic spin,
  output logic tach
);
  int cnt; // Cycles into the current tach half period
  int onCnt; // Cycles seen with the PWM pin high
  initial begin
    tach = 1'b1;
    cnt = 0;
    onCnt = 0;
  end
  // Pin high means drive on
  always @(posedge clk) begin
    if (pwmPin) begin
      onCnt <= onCnt + 1;
    end
  end
  always @(posedge clk) begin
    if (!spin) begin
      cnt <= 0;
      tach <= 1'b1;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      tach <= ~tach;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule : fan_model
`default_nettype wire

// [tb/fan_lut_smoothing_tach_tb.sv]
// Purpose: Self-checking bench for the fan block
// Assumes: Short smoothing base so ramps finish quickly
// Notes: Table entry i is 10+10i degrees with duty 16(i+1)
`timescale 1ns/100ps
`default_nettype none
module fan_lut_smoothing_tach_tb;
  localparam int BASE = 20; // Shortened smoothing interval
  logic clk, nrst, regWrEn, critTempOut, tachIn, pwmOut, pwmOe, remoteModeBeta, spin;
  logic [7:0] regAddr, regWrData, regRdData, dutyCycle, lastDuty, d, e, hi, lo, step;
  logic [8:0] remoteTemp;
  logic [8:0] corner [4] = '{9'd41, 9'd40, 9'd38, 9'd36}; // Threshold temperatures
  int num_errors, checked, cycles, mIdx, hyst, cnt, rv, tot, n;
  bit smoothOn, half;
  fan_lut_smoothing_tach #(.SMOOTH_BASE_CYCLES(BASE), .LUT_PAIRS(12)) u_dut (.clk(clk),
    .nrst(nrst), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
    .remoteTemp(remoteTemp), .critTempOut(critTempOut), .tachIn(tachIn),
    .regRdData(regRdData), .pwmOut(pwmOut), .pwmOe(pwmOe), .dutyCycle(dutyCycle),
    .remoteModeBeta(remoteModeBeta));
  fan_model #(.HALF(2220)) u_fan (.clk(clk), .pwmPin(!pwmOe), .spin(spin), .tach(tachIn));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick
  task automatic check(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    regAddr = a;
    regWrData = v;
    regWrEn = 1'b1;
    tick(1);
    regWrEn = 1'b0;
    tick(1);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    regAddr = a;
    tick(2);
    v = regRdData;
  endtask : rd
  task automatic give_verdict();
    $display("Errors %0d, checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict
  // Duty expected from the table, tracking which entries are active
  function automatic logic [7:0] expDuty(input logic [8:0] t, input bit hd);
    int ct, k, sp;
    ct = hd ? int'(t) : int'(t & 9'h1fe);
    k = 0;
    for (int i = 0; i < 12; i++) begin
      sp = 10 + 10 * i;
      if (i < mIdx) sp = (sp > hyst) ? sp - hyst : 0;
      if (ct > 2 * sp) k++;
    end
    mIdx = k;
    return 8'(16 * k);
  endfunction : expDuty
  // Ramp watch and run ceiling
  always @(posedge clk) begin
    if (smoothOn && dutyCycle !== lastDuty && (dutyCycle - lastDuty) !== step
        && (lastDuty - dutyCycle) !== step) begin
      num_errors++;
      $display("CHECK FAILED %0t ramp step size", $time);
    end
    lastDuty <= dutyCycle;
    cycles++;
    if (cycles == 90000) begin
      num_errors++;
      give_verdict();
    end
  end
  initial begin
    nrst = 0; regAddr = 0; regWrData = 0; regWrEn = 0; remoteTemp = 0; critTempOut = 0;
    spin = 1; smoothOn = 0; step = 1; mIdx = 0; hyst = 2; half = 0; lastDuty = 0;
    rv = $urandom(32'h0c009122);
    tick(12);
    nrst = 1;
    wr(8'h69, 8'(hyst));
    for (int i = 0; i < 12; i++) begin
      wr(8'(8'h50 + 2 * i), 8'(10 + 10 * i));
      wr(8'(8'h51 + 2 * i), 8'(16 * (i + 1)));
    end
    wr(8'h68, 8'h24); // beta mode only for an integrated sensor
    rd(8'h68, d);
    check(d === 8'h24 && remoteModeBeta === 1'b1, "config readback");
    rd(8'h70, d);
    check(d === 8'h00, "unmapped read");
    for (int k = 0; k < 40; k++) begin
      if (k == 0 || k == 20) begin
        half = (k == 20);
        wr(8'h68, half ? 8'h0c : 8'h04);
        e = expDuty(remoteTemp, half);
      end
      remoteTemp = (k % 20 < 4) ? corner[k % 4] : 9'($urandom_range(300));
      e = expDuty(remoteTemp, half);
      tick(4);
      check(dutyCycle === e, "table duty");
    end
    cnt = u_fan.onCnt;
    tick(256);
    check(u_fan.onCnt - cnt == int'(e) && pwmOut === 1'b0, "pin duty ratio");
    critTempOut = 1;
    tick(2);
    check(dutyCycle === 8'hff, "critical duty");
    cnt = 0;
    repeat (256) begin
      tick(1);
      if (pwmOe !== 1'b0) cnt++;
    end
    check(cnt == 0, "pin released at full duty");
    critTempOut = 0;
    for (int k = 0; k < 8; k++) begin
      remoteTemp = 0;
      wr(8'h68, 8'h04);
      tick(4);
      step = k[0] ? 8'h10 : 8'h01;
      n = 32 / step;
      wr(8'h68, 8'(8'h10 | (k[0] ? 8'h00 : 8'h04) | (k >> 1)));
      smoothOn = 1;
      for (int dir = 0; dir < 2; dir++) begin
        remoteTemp = dir ? 9'd0 : 9'd51;
        e = dir ? 8'h00 : 8'h20;
        cnt = 0;
        while (dutyCycle !== e && cnt < 8000) begin
          tick(1);
          cnt++;
        end
        check(cnt >= (n - 1) * (BASE << (k >> 1)) && cnt <= n * (BASE << (k >> 1)) + 4,
              "ramp time");
      end
      smoothOn = 0;
    end
    rd(8'h46, lo);
    rd(8'h47, hi);
    tot = int'(lo) + 256 * int'(hi);
    check(tot >= 19 && tot <= 21, "tach count");
    check(tot > 0 && 5400000 / tot > 256000 && 5400000 / tot < 285000,
          "fan speed");
    // Fan stops: the last measurement must stand while no revolution ends
    spin = 0;
    tick(10);
    rd(8'h46, lo);
    rd(8'h47, hi);
    n = int'(lo) + 256 * int'(hi);
    tick(9000);
    rd(8'h46, lo);
    rd(8'h47, hi);
    check(int'(lo) + 256 * int'(hi) == n, "count held while fan stands");
    give_verdict();
  end
endmodule : fan_lut_smoothing_tach_tb
`default_nettype wire
